// >>> hdl/dtp_pkg.sv
// Types shared by the dual two-bit port block.
package dtp_pkg;

  // ----------------------------------------------------------------------
  // Bus request and pin drive carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } dtp_bus_req_t;

  typedef struct packed {
    logic [1:0] out;
    logic [1:0] oe;
  } dtp_pin_drive_t;

endpackage

// >>> hdl/dtp_ports.sv
// Two two-bit general-purpose ports sharing pins with timer and serial.
`timescale 1ns/100ps
`include "dtp_regs.svh"

module dtp_ports (
  // Clock, reset and clock enable.
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clk_en,
  // Register port.
  input dtp_pkg::dtp_bus_req_t bus_req,
  output logic [7:0] rd_data,
  // Timer-sharing pins.
  input wire logic [1:0] tpin_in,
  output dtp_pkg::dtp_pin_drive_t tpin_drv,
  // Serial-sharing pins.
  input wire logic [1:0] spin_in,
  output dtp_pkg::dtp_pin_drive_t spin_drv,
  output logic [1:0] spin_pullup_en,
  // Timer counter side.
  input wire logic pulse_out_a,
  input wire logic pulse_out_b,
  input wire logic pwm_out_a,
  input wire logic pwm_out_b,
  output logic timer_in_a,
  output logic timer_in_b,
  // Serial channel side.
  input wire logic serial_transmit_line,
  output logic [1:0] serial_receive_line
);
  import dtp_pkg::*;

  // ----------------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------------

  // Pads a two-bit field to a register byte with zero reserved bits.
  function automatic logic [7:0] pad_field(input logic [1:0] f);
    pad_field = {`DTP_ZERO_PAD, f};
  endfunction

  // Pin level seen by software: only bits whose read gate is open.
  function automatic logic [1:0] gate_pins(input logic [1:0] pins,
                                           input logic [1:0] open_bits);
    gate_pins = pins & open_bits;
  endfunction

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  logic [1:0] timer_port_out_latch_reg, timer_port_out_latch_next;
  logic [1:0] timer_port_direction_reg, timer_port_direction_next;
  logic [1:0] timer_port_alt_select_reg, timer_port_alt_select_next;
  logic [1:0] serial_port_out_latch_reg, serial_port_out_latch_next;
  logic [1:0] serial_port_direction_reg, serial_port_direction_next;
  logic [1:0] serial_port_alt_select_reg, serial_port_alt_select_next;
  logic [1:0] serial_port_drive_type_reg, serial_port_drive_type_next;
  logic [1:0] serial_port_pullup_reg, serial_port_pullup_next;

  // Write decode; a write to a read-only or unmapped address is dropped.
  always_comb begin
    timer_port_out_latch_next = timer_port_out_latch_reg;
    timer_port_direction_next = timer_port_direction_reg;
    timer_port_alt_select_next = timer_port_alt_select_reg;
    serial_port_out_latch_next = serial_port_out_latch_reg;
    serial_port_direction_next = serial_port_direction_reg;
    serial_port_alt_select_next = serial_port_alt_select_reg;
    serial_port_drive_type_next = serial_port_drive_type_reg;
    serial_port_pullup_next = serial_port_pullup_reg;
    if (clk_en && bus_req.wr) begin
      unique case (bus_req.addr)
        `DTP_TLAT_ADDR: timer_port_out_latch_next = bus_req.wdata[1:0];
        `DTP_TDIR_ADDR: timer_port_direction_next = bus_req.wdata[1:0];
        `DTP_TALT_ADDR: timer_port_alt_select_next = bus_req.wdata[1:0];
        `DTP_SLAT_ADDR: serial_port_out_latch_next = bus_req.wdata[1:0];
        `DTP_SDIR_ADDR: serial_port_direction_next = bus_req.wdata[1:0];
        `DTP_SALT_ADDR: serial_port_alt_select_next = bus_req.wdata[1:0];
        `DTP_SOD_ADDR: serial_port_drive_type_next = bus_req.wdata[1:0];
        `DTP_SPU_ADDR: serial_port_pullup_next = bus_req.wdata[1:0];
        default: begin
        end
      endcase
    end
  end

  // All control fields clear at reset, so every pin starts as an input.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      timer_port_out_latch_reg <= `DTP_FIELD_RST;
      timer_port_direction_reg <= `DTP_FIELD_RST;   // see RULE3
      timer_port_alt_select_reg <= `DTP_FIELD_RST;  // see RULE4
      serial_port_out_latch_reg <= `DTP_FIELD_RST;
      serial_port_direction_reg <= `DTP_FIELD_RST;  // see RULE11
      serial_port_alt_select_reg <= `DTP_FIELD_RST; // see RULE12
      serial_port_drive_type_reg <= `DTP_FIELD_RST; // see RULE8
      serial_port_pullup_reg <= `DTP_FIELD_RST;
    end else begin
      timer_port_out_latch_reg <= timer_port_out_latch_next;
      timer_port_direction_reg <= timer_port_direction_next;
      timer_port_alt_select_reg <= timer_port_alt_select_next;
      serial_port_out_latch_reg <= serial_port_out_latch_next;
      serial_port_direction_reg <= serial_port_direction_next;
      serial_port_alt_select_reg <= serial_port_alt_select_next;
      serial_port_drive_type_reg <= serial_port_drive_type_next;
      serial_port_pullup_reg <= serial_port_pullup_next;
    end
  end

  // ----------------------------------------------------------------------
  // Pin drive, pin read and side-channel outputs
  // ----------------------------------------------------------------------
  dtp_pin_drive_t tpin_drv_reg, tpin_drv_next;
  dtp_pin_drive_t spin_drv_reg, spin_drv_next;
  logic [1:0] pullup_reg, pullup_next;
  logic [1:0] tmr_in_reg, tmr_in_next;
  logic [1:0] rx_reg, rx_next;
  logic [7:0] rd_data_reg, rd_data_next;
  logic [1:0] t_alt;
  logic [1:0] t_src;
  logic [1:0] s_src;
  logic [1:0] t_open;
  logic [1:0] s_open;

  // Source selection and read gates for both ports.
  always_comb begin
    // The timer raises only one of pulse or PWM per channel at a time.
    t_alt = {pulse_out_b | pwm_out_b, pulse_out_a | pwm_out_a};
    t_src = (t_alt & timer_port_alt_select_reg) |
            (timer_port_out_latch_reg & ~timer_port_alt_select_reg);
    s_src = ({2{serial_transmit_line}} & serial_port_alt_select_reg) |
            (serial_port_out_latch_reg & ~serial_port_alt_select_reg);
    t_open = ~timer_port_direction_reg;
    s_open = ~serial_port_direction_reg | serial_port_drive_type_reg;
  end

  // Next values of every registered output; frozen while clk_en is low.
  always_comb begin
    tpin_drv_next = tpin_drv_reg;
    spin_drv_next = spin_drv_reg;
    pullup_next = pullup_reg;
    tmr_in_next = tmr_in_reg;
    rx_next = rx_reg;
    rd_data_next = rd_data_reg;
    if (clk_en) begin
      // Timer pins are always push-pull.
      tpin_drv_next.out = t_src;                       // see RULE2 RULE4
      tpin_drv_next.oe = timer_port_direction_reg;     // see RULE1 RULE15
      // Open drain never drives high; a high value just releases the pin.
      spin_drv_next.out = s_src & ~serial_port_drive_type_reg; // see RULE7
      spin_drv_next.oe = serial_port_direction_reg &
                         (~serial_port_drive_type_reg | ~s_src); // see RULE9
      pullup_next = serial_port_pullup_reg & s_open;   // see RULE10
      tmr_in_next = gate_pins(tpin_in, t_open);        // see RULE3
      // A receive line idles high while its pin is an output.
      rx_next = spin_in | serial_port_direction_reg;   // see RULE11 RULE6
      rd_data_next = `DTP_DATA_RST;
      if (bus_req.rd) begin
        unique case (bus_req.addr)
          `DTP_TLAT_ADDR: rd_data_next = pad_field(timer_port_out_latch_reg);
          `DTP_TDIR_ADDR: rd_data_next = pad_field(timer_port_direction_reg);
          `DTP_TALT_ADDR: rd_data_next = pad_field(timer_port_alt_select_reg);
          `DTP_SLAT_ADDR: rd_data_next = pad_field(serial_port_out_latch_reg);
          `DTP_SDIR_ADDR: rd_data_next = pad_field(serial_port_direction_reg);
          `DTP_SALT_ADDR:
            rd_data_next = pad_field(serial_port_alt_select_reg);
          `DTP_SOD_ADDR: rd_data_next = pad_field(serial_port_drive_type_reg);
          `DTP_SPU_ADDR: rd_data_next = pad_field(serial_port_pullup_reg);
          `DTP_TRD_ADDR:
            rd_data_next = pad_field(gate_pins(tpin_in, t_open)); // see RULE5
          `DTP_SRD_ADDR:
            rd_data_next = pad_field(gate_pins(spin_in, s_open)); // see RULE14
          default: rd_data_next = `DTP_DATA_RST;
        endcase
      end
    end
  end

  // Output flip-flops; pins come out of reset released.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tpin_drv_reg <= '0;
      spin_drv_reg <= '0;
      pullup_reg <= `DTP_FIELD_RST;
      tmr_in_reg <= `DTP_FIELD_RST;
      rx_reg <= `DTP_FIELD_RST;
      rd_data_reg <= `DTP_DATA_RST;
    end else begin
      tpin_drv_reg <= tpin_drv_next;
      spin_drv_reg <= spin_drv_next;
      pullup_reg <= pullup_next;
      tmr_in_reg <= tmr_in_next;
      rx_reg <= rx_next;
      rd_data_reg <= rd_data_next;
    end
  end

  // Top-level outputs straight from flip-flops.
  assign tpin_drv = tpin_drv_reg;
  assign spin_drv = spin_drv_reg;
  assign spin_pullup_en = pullup_reg;
  assign timer_in_a = tmr_in_reg[0];
  assign timer_in_b = tmr_in_reg[1];
  assign serial_receive_line = rx_reg;
  assign rd_data = rd_data_reg;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  // A write to the timer direction register followed by its read.
  sequence tdir_write_s;
    clk_en && bus_req.wr && bus_req.addr == `DTP_TDIR_ADDR;
  endsequence

  sequence tdir_read_s;
    clk_en && bus_req.rd && bus_req.addr == `DTP_TDIR_ADDR;
  endsequence

  property tdir_readback_p;
    logic [1:0] v;
    (tdir_write_s, v = bus_req.wdata[1:0]) ##1
      (tdir_read_s and !(clk_en && bus_req.wr)) |=>
      rd_data == {`DTP_ZERO_PAD, v};
  endproperty

  timer_dir_readback_a: assert property (tdir_readback_p) // see RULE3
    else $error("timer direction readback differs from written value");

  // Timer pin read is zero for bits in output mode.
  timer_pin_read_a: assert property ( // see RULE5
    (clk_en && bus_req.rd && bus_req.addr == `DTP_TRD_ADDR) |=>
      rd_data[7:2] == `DTP_ZERO_PAD &&
      (rd_data[1:0] & $past(timer_port_direction_reg)) == 2'h0 &&
      rd_data[1:0] == ($past(tpin_in) & ~$past(timer_port_direction_reg)))
    else $error("timer pin read not gated by direction");

  // Serial pin read shows the pin in input or open-drain mode.
  serial_pin_read_a: assert property ( // see RULE14
    (clk_en && bus_req.rd && bus_req.addr == `DTP_SRD_ADDR) |=>
      rd_data[1:0] == ($past(spin_in) &
        (~$past(serial_port_direction_reg) |
         $past(serial_port_drive_type_reg))))
    else $error("serial pin read gate wrong");

  // Read data stand only in the cycle after the read strobe.
  read_data_clear_a: assert property (
    (clk_en && !bus_req.rd) |=> rd_data == `DTP_DATA_RST)
    else $error("read data present without a read");

  // Open drain never drives the pin high.
  open_drain_high_a: assert property ( // see RULE9
    (clk_en && serial_port_drive_type_reg[0]) |=>
      !(spin_drv.oe[0] && spin_drv.out[0]))
    else $error("open-drain pin driven high");

  // Pull-up is off for a push-pull output.
  pullup_gate_a: assert property ( // see RULE10
    (clk_en && serial_port_direction_reg[1] &&
     !serial_port_drive_type_reg[1]) |=> !spin_pullup_en[1])
    else $error("pull-up connected on push-pull output");

  // Timer pin enable tracks its direction bit one cycle later.
  timer_pin_enable_a: assert property ( // see RULE15
    clk_en |=> tpin_drv.oe == $past(timer_port_direction_reg))
    else $error("timer pin enable does not follow direction");

  // Alternate function puts the timer output on the pin.
  timer_alt_drive_a: assert property ( // see RULE4
    (clk_en && timer_port_alt_select_reg[0]) |=>
      tpin_drv.out[0] == $past(pulse_out_a | pwm_out_a))
    else $error("timer alternate output not on pin");

  // Serial transmit drives a push-pull pin selected for it.
  serial_tx_drive_a: assert property ( // see RULE12
    (clk_en && serial_port_alt_select_reg[1] &&
     !serial_port_drive_type_reg[1]) |=>
      spin_drv.out[1] == $past(serial_transmit_line))
    else $error("serial transmit not on pin");

  // Read data and both pin drives hold still while the clock enable is low.
  freeze_hold_a: assert property (
    !clk_en |=> $stable(rd_data) && $stable(tpin_drv) && $stable(spin_drv))
    else $error("outputs changed while clock enable low");

  // An output pin in port function drives its latch bit.
  timer_latch_drive_a: assert property ( // see RULE2
    (clk_en && timer_port_direction_reg[1] &&
     !timer_port_alt_select_reg[1]) |=>
      tpin_drv.oe[1] &&
      tpin_drv.out[1] == $past(timer_port_out_latch_reg[1]))
    else $error("timer latch bit not on output pin");

  // A timer pin in output mode gives its counter input a low level.
  timer_in_gate_a: assert property ( // see RULE3
    (clk_en && timer_port_direction_reg[0]) |=> !timer_in_a)
    else $error("timer counter input not gated in output mode");

  // A low latch bit pulls a serial output pin low in either drive type.
  serial_low_drive_a: assert property ( // see RULE7
    (clk_en && serial_port_direction_reg[0] &&
     !serial_port_alt_select_reg[0] && !serial_port_out_latch_reg[0]) |=>
      spin_drv.oe[0] && !spin_drv.out[0])
    else $error("serial output pin not driven low");

  // An enabled pull-up connects while its pin is an input.
  pullup_connect_a: assert property ( // see RULE10
    (clk_en && serial_port_pullup_reg[0] && !serial_port_direction_reg[0])
      |=> spin_pullup_en[0])
    else $error("pull-up not connected on input pin");

  // A receive line idles high while its pin is an output.
  serial_rx_idle_a: assert property ( // see RULE11
    (clk_en && serial_port_direction_reg[1]) |=> serial_receive_line[1])
    else $error("serial receive line not idle high");

  // A receive line follows its pin while the pin is an input.
  serial_rx_pin_a: assert property ( // see RULE11
    (clk_en && !serial_port_direction_reg[0]) |=>
      serial_receive_line[0] == $past(spin_in[0]))
    else $error("serial receive line does not follow pin");

endmodule

// >>> hdl/dtp_regs.svh
// Register offsets, field widths and reset values of the two small ports.
// How it works
// RULE1: Timer-sharing port has two pins, each set as input or output.
// RULE2: Timer port output with port function drives latch bit level.
// RULE3: Timer direction 0 is input to timer counter, 1 is output; reset 0.
// RULE4: Timer function bit picks latch when 0, pulse/PWM output when 1.
// RULE5: Timer pin read returns pin level in input mode, else zero.
// RULE6: Serial-sharing port has two pins, each input or output.
// RULE7: Serial port output: latch 0 drives low, latch 1 releases high; a push-pull pin here drives latch 1 high.
// RULE8: Serial drive-type bit: 0 push-pull, 1 sink-only open drain; reset 0.
// RULE9: Open drain with high value disables the high-side driver.
// RULE10: Pull-up connects only if enabled and input or open-drain output.
// RULE11: Serial direction 0 feeds serial receive, 1 is output; reset 0.
// RULE12: Serial function bit picks latch when 0, serial transmit when 1.
// RULE13: Software must also program the serial routing selection elsewhere.
// RULE14: Serial pin read gives pin level in input or open drain, else zero.
// RULE15: Driver enable follows direction; value from alternate or latch.
`ifndef DTP_REGS_SVH
`define DTP_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define DTP_TLAT_ADDR 12'h008
`define DTP_SLAT_ADDR 12'h009
`define DTP_TRD_ADDR 12'h015
`define DTP_SRD_ADDR 12'h016
`define DTP_TDIR_ADDR 12'hf22
`define DTP_SDIR_ADDR 12'hf23
`define DTP_SPU_ADDR 12'hf30
`define DTP_TALT_ADDR 12'hf3c
`define DTP_SALT_ADDR 12'hf3d
`define DTP_SOD_ADDR 12'hf4a

// ----------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------
`define DTP_PORT_W 2
`define DTP_FIELD_RST 2'h0
`define DTP_DATA_RST 8'h00
`define DTP_ZERO_PAD 6'h00

`endif

// >>> sim/dtp_pin_board.sv
// Board model that resolves the levels of the four shared pins.
`timescale 1ns/100ps
module dtp_pin_board (
  // Clock for the floating-pin pattern.
  input wire logic ref_clk,
  // Drive from the ports.
  input dtp_pkg::dtp_pin_drive_t tpin_drv,
  input dtp_pkg::dtp_pin_drive_t spin_drv,
  input wire logic [1:0] spin_pullup_en,
  // Board sources, timer pins in bits 1:0, serial pins in bits 3:2.
  input wire logic [3:0] ext_en,
  input wire logic [3:0] ext_val,
  // Resolved pin levels.
  output logic [1:0] tpin_in,
  output logic [1:0] spin_in
);
  import dtp_pkg::*;
  logic [3:0] lvl;
  logic [3:0] last_reg = 4'h0;
  logic [3:0] oe;
  logic [3:0] val;
  logic [3:0] pu;
  // Gather the drivers of all four pins.
  assign oe = {spin_drv.oe, tpin_drv.oe};
  assign val = {spin_drv.out, tpin_drv.out};
  assign pu = {spin_pullup_en, 2'h0};
  // Port drive wins, then the board, then the pull-up; a floating pin
  // toggles each cycle so that a stale level never passes for a good one.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (oe[i]) begin
        lvl[i] = val[i];
      end else if (ext_en[i]) begin
        lvl[i] = ext_val[i];
      end else begin
        lvl[i] = pu[i] | ~last_reg[i];
      end
    end
  end
  // Remember the last level for the floating pattern.
  always_ff @(posedge ref_clk) begin
    last_reg <= lvl;
  end
  // Serial routing is chosen outside the ports; the board sees pins only.
  assign tpin_in = lvl[1:0];
  assign spin_in = lvl[3:2];
endmodule

// >>> sim/tb_top.sv
// Self-checking testbench of the dual two-bit ports.
`timescale 1ns/100ps
`include "dtp_regs.svh"
module tb_top;
  import dtp_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic clk_en = 1'b1;
  dtp_bus_req_t bus_req = '0;
  logic [7:0] rd_data;
  logic [1:0] tpin_in, spin_in, spin_pullup_en, serial_receive_line;
  dtp_pin_drive_t tpin_drv, spin_drv;
  logic pulse_out_a = 1'b0;
  logic pulse_out_b = 1'b0;
  logic pwm_out_a = 1'b0;
  logic pwm_out_b = 1'b0;
  logic serial_transmit_line = 1'b0;
  logic timer_in_a, timer_in_b;
  logic [3:0] ext_en = 4'h0;
  logic [3:0] ext_val = 4'h0;
  int fails = 0;
  int checks_done = 0;
  logic [11:0] addr_tab [8] = '{`DTP_TLAT_ADDR, `DTP_SLAT_ADDR,
    `DTP_TDIR_ADDR, `DTP_SDIR_ADDR, `DTP_SPU_ADDR, `DTP_TALT_ADDR,
    `DTP_SALT_ADDR, `DTP_SOD_ADDR};
  // Clock of 5 ns period.
  always #2.5 ref_clk = ~ref_clk;
  // Device and board.
  dtp_ports u_dut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
    .bus_req(bus_req), .rd_data(rd_data), .tpin_in(tpin_in),
    .tpin_drv(tpin_drv), .spin_in(spin_in), .spin_drv(spin_drv),
    .spin_pullup_en(spin_pullup_en), .pulse_out_a(pulse_out_a),
    .pulse_out_b(pulse_out_b), .pwm_out_a(pwm_out_a),
    .pwm_out_b(pwm_out_b), .timer_in_a(timer_in_a),
    .timer_in_b(timer_in_b), .serial_transmit_line(serial_transmit_line),
    .serial_receive_line(serial_receive_line));
  dtp_pin_board u_board (.ref_clk(ref_clk), .tpin_drv(tpin_drv),
    .spin_drv(spin_drv), .spin_pullup_en(spin_pullup_en),
    .ext_en(ext_en), .ext_val(ext_val), .tpin_in(tpin_in),
    .spin_in(spin_in));
  // Compare and count.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One-cycle register write.
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_req.addr <= a;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask
  // One-cycle read, data judged in the following cycle.
  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    bus_req.addr <= a;
    bus_req.rd <= 1'b1;
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    @(negedge ref_clk);
    chk(rd_data, e);
  endtask
  // Let registered pin outputs follow the last change.
  task automatic settle;
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  // Reset values, field width, unmapped place and frozen clock.
  task automatic t_regs;
    for (int i = 0; i < 8; i++) begin
      rd_chk(addr_tab[i], 8'h00);
      wr(addr_tab[i], 8'hff);
      rd_chk(addr_tab[i], 8'h03);
      wr(addr_tab[i], 8'h00);
    end
    wr(12'h100, 8'hff);
    rd_chk(12'h100, 8'h00);
    // Write then read with no gap between the strobes.
    @(posedge ref_clk);
    bus_req.addr <= `DTP_TDIR_ADDR;
    bus_req.wdata <= 8'h02;
    bus_req.wr <= 1'b1;
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
    bus_req.rd <= 1'b1;
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    @(negedge ref_clk);
    chk(rd_data, 8'h02);
    wr(`DTP_TDIR_ADDR, 8'h00);
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr(`DTP_TDIR_ADDR, 8'h03);
    @(posedge ref_clk);
    clk_en <= 1'b1;
    rd_chk(`DTP_TDIR_ADDR, 8'h00);
  endtask
  // Timer port input, latch output and pulse/PWM outputs.
  task automatic t_timer;
    @(posedge ref_clk);
    ext_en <= 4'h3;
    ext_val <= 4'h1;
    settle;
    chk({6'h00, timer_in_b, timer_in_a}, 8'h01);
    rd_chk(`DTP_TRD_ADDR, 8'h01);
    @(posedge ref_clk);
    ext_en <= 4'h0;
    wr(`DTP_TLAT_ADDR, 8'h02);
    wr(`DTP_TDIR_ADDR, 8'h03);
    settle;
    chk({4'h0, tpin_drv}, 8'h0b);
    chk({6'h00, timer_in_b, timer_in_a}, 8'h00);
    rd_chk(`DTP_TRD_ADDR, 8'h00);
    @(posedge ref_clk);
    pulse_out_a <= 1'b1;
    pwm_out_b <= 1'b1;
    wr(`DTP_TALT_ADDR, 8'h03);
    settle;
    chk({4'h0, tpin_drv}, 8'h0f);
    @(posedge ref_clk);
    pulse_out_a <= 1'b0;
    pwm_out_a <= 1'b1;
    pwm_out_b <= 1'b0;
    settle;
    chk({4'h0, tpin_drv}, 8'h07);
    @(posedge ref_clk);
    pwm_out_a <= 1'b0;
    pulse_out_b <= 1'b1;
    settle;
    chk({4'h0, tpin_drv}, 8'h0b);
    wr(`DTP_TDIR_ADDR, 8'h00);
    settle;
    chk({6'h00, tpin_drv.oe}, 8'h00);
  endtask
  // Serial port push-pull, open drain, transmit source and input.
  task automatic t_serial;
    wr(`DTP_SLAT_ADDR, 8'h02);
    wr(`DTP_SPU_ADDR, 8'h03);
    wr(`DTP_SDIR_ADDR, 8'h03);
    settle;
    chk({4'h0, spin_drv}, 8'h0b);
    chk({6'h00, spin_pullup_en}, 8'h00);
    chk({6'h00, serial_receive_line}, 8'h03);
    rd_chk(`DTP_SRD_ADDR, 8'h00);
    wr(`DTP_SOD_ADDR, 8'h03);
    settle;
    chk({4'h0, spin_drv}, 8'h01);
    chk({6'h00, spin_pullup_en}, 8'h03);
    rd_chk(`DTP_SRD_ADDR, 8'h02);
    @(posedge ref_clk);
    serial_transmit_line <= 1'b1;
    wr(`DTP_SALT_ADDR, 8'h01);
    settle;
    chk({4'h0, spin_drv}, 8'h00);
    wr(`DTP_SOD_ADDR, 8'h00);
    settle;
    chk({4'h0, spin_drv}, 8'h0f);
    @(posedge ref_clk);
    serial_transmit_line <= 1'b0;
    settle;
    chk({4'h0, spin_drv}, 8'h0b);
    wr(`DTP_SDIR_ADDR, 8'h00);
    @(posedge ref_clk);
    ext_en <= 4'h4;
    ext_val <= 4'h0;
    settle;
    chk({6'h00, serial_receive_line}, 8'h02);
    chk({6'h00, spin_pullup_en}, 8'h03);
    rd_chk(`DTP_SRD_ADDR, 8'h02);
  endtask
  // Verdict and end of run.
  task automatic stop_test;
    if (fails == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Main sequence: reset for 8 cycles, then the scenarios.
  initial begin
    repeat (7) @(posedge ref_clk);
    @(negedge ref_clk);
    chk({spin_drv, tpin_drv}, 8'h00);
    @(posedge ref_clk);
    reset <= 1'b0;
    t_regs;
    t_timer;
    t_serial;
    stop_test;
  end
  // Cut a hang short.
  initial begin
    #100000;
    fails++;
    stop_test;
  end
endmodule
